/* File: include/scra_defs.vh */
`ifndef SCRA_DEFS_VH
`define SCRA_DEFS_VH

// Control register indices
`define SCRA_IDX_MODE_CTL    4'h0
`define SCRA_IDX_FAULT_ADDR  4'h2
`define SCRA_IDX_TABLE_BASE  4'h3
`define SCRA_IDX_EXTRA_CTL   4'h4
`define SCRA_IDX_PRIO_THRESH 4'h8

// Widths
`define SCRA_REG_W           64
`define SCRA_HALF_W          32
`define SCRA_PRIO_W          4
`define SCRA_ERR_W           16

// Reset values
`define SCRA_RST_MODE_CTL    64'h0000000000000010
`define SCRA_RST_ZERO        64'h0000000000000000
`define SCRA_RST_FLAGS       64'h0000000000000002

// Write masks
`define SCRA_MASK_ALL        64'hFFFFFFFFFFFFFFFF
`define SCRA_MASK_LOW32      64'h00000000FFFFFFFF
`define SCRA_MASK_PRIO       64'h000000000000000F

// Error code carried with a protection fault
`define SCRA_GP_ERR_CODE     16'h0000

// Descriptor base selectors
`define SCRA_DT_GLOBAL       2'h0
`define SCRA_DT_VECTOR       2'h1
`define SCRA_DT_LOCAL        2'h2
`define SCRA_DT_TASK         2'h3

// Structure sizes in bytes
`define SCRA_VEC_ENTRY_LONG  5'h10
`define SCRA_VEC_ENTRY_LEG   5'h08
`define SCRA_PUSH_LONG       4'h8
`define SCRA_PUSH_LEG32      4'h4
`define SCRA_PUSH_LEG16      4'h2
`define SCRA_GATE_LONG       5'h10
`define SCRA_GATE_LEG        5'h08
`define SCRA_PSEUDO_LONG     4'hA
`define SCRA_PSEUDO_LEG      4'h6
`define SCRA_SYS_ENTRY_LONG  5'h10
`define SCRA_SYS_ENTRY_LEG   5'h08

// Paging depth
`define SCRA_PAGING_LONG     3'h4
`define SCRA_PAGING_PAE      3'h3
`define SCRA_PAGING_PLAIN    3'h2

`endif

/* File: design/scra_reg.v */
`include "scra_defs.vh"

module scra_reg #(
  parameter [63:0] RST_VAL = `SCRA_RST_ZERO,
  parameter [63:0] WR_MASK = `SCRA_MASK_ALL
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // Write port
  input  wire        wr_en,
  input  wire [63:0] wr_data,
  // Stored value
  output wire [63:0] value
);

  reg [63:0] value_q;

  // Masked bits never store, so they read as zero unless RST_VAL sets them at reset
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      value_q <= RST_VAL;
    end else if (wr_en) begin
      value_q <= wr_data & WR_MASK;
    end
  end

  assign value = value_q;

endmodule // scra_reg

/* File: design/scra_mode.v */
`include "scra_defs.vh"

module scra_mode (
  // Mode inputs
  input  wire       long_active,
  input  wire       code_long,
  input  wire       pae_on,
  input  wire       gate32,
  // Decoded mode
  output wire       mode_64,
  output wire       mode_compat,
  output wire       mode_legacy,
  // Structural attributes
  output wire       real_v86_ok,
  output wire       hw_task_switch_ok,
  output wire       seg_base_ignore,
  output wire       seg_limit_ignore,
  output wire [4:0] vec_entry_bytes,
  output wire [3:0] push_bytes,
  output wire       stack_ptr_push_always,
  output wire       stack_seg_keep,
  output wire       call_gate16_illegal,
  output wire [4:0] call_gate32_bytes,
  output wire [3:0] pseudo_desc_bytes,
  output wire [4:0] sys_entry_bytes,
  output wire [2:0] paging_levels
);

  assign mode_64     = long_active & code_long;
  assign mode_compat = long_active & ~code_long;
  assign mode_legacy = ~long_active;

  assign real_v86_ok           = mode_legacy;
  assign hw_task_switch_ok     = mode_legacy;
  assign seg_base_ignore       = mode_64;
  assign seg_limit_ignore      = mode_64;
  assign vec_entry_bytes       = long_active ? `SCRA_VEC_ENTRY_LONG : `SCRA_VEC_ENTRY_LEG;
  assign push_bytes            = long_active ? `SCRA_PUSH_LONG :
                                 (gate32 ? `SCRA_PUSH_LEG32 : `SCRA_PUSH_LEG16);
  assign stack_ptr_push_always = long_active;
  assign stack_seg_keep        = long_active;
  assign call_gate16_illegal   = mode_64;
  assign call_gate32_bytes     = mode_64 ? `SCRA_GATE_LONG : `SCRA_GATE_LEG;
  assign pseudo_desc_bytes     = mode_64 ? `SCRA_PSEUDO_LONG : `SCRA_PSEUDO_LEG;
  assign sys_entry_bytes       = mode_64 ? `SCRA_SYS_ENTRY_LONG : `SCRA_SYS_ENTRY_LEG;
  assign paging_levels         = long_active ? `SCRA_PAGING_LONG :
                                 (pae_on ? `SCRA_PAGING_PAE : `SCRA_PAGING_PLAIN);

endmodule // scra_mode

/* File: design/scra_top.v */
`include "scra_defs.vh"

module scra_top #(
  parameter        PA_WIDTH = 40,
  parameter [5:0]  PAE_BIT  = 6'h05
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // Operating mode from the core
  input  wire        long_active,
  input  wire        code_long,
  input  wire        gate32,
  // Control register move request
  input  wire        req_valid,
  input  wire        req_write,
  input  wire [3:0]  req_index,
  input  wire        req_rex,
  input  wire        req_opsize,
  input  wire [63:0] req_wdata,
  // Control register move answer
  output reg         rsp_valid,
  output reg  [63:0] rsp_rdata,
  output reg         rsp_gp_fault,
  output reg  [15:0] rsp_err_code,
  output reg         rsp_ud_fault,
  // Flags load
  input  wire        flags_wr,
  input  wire [63:0] flags_wdata,
  // Feature enable load
  input  wire        extended_feature_enable_reg_wr,
  input  wire [63:0] extended_feature_enable_reg_wdata,
  // Page fault report
  input  wire        pf_valid,
  input  wire [63:0] pf_addr,
  // Descriptor table base load
  input  wire        dt_load_valid,
  input  wire [1:0]  dt_load_sel,
  input  wire [63:0] dt_load_base,
  // Register contents
  output wire [63:0] mode_feature_control_reg,
  output wire [63:0] fault_address_reg,
  output wire [63:0] table_base_reg,
  output wire [63:0] extra_mode_control_reg,
  output wire [3:0]  priority_threshold_reg,
  output wire [63:0] flags_status_control_reg,
  output wire [63:0] extended_feature_enable_reg,
  output wire [63:0] global_table_base,
  output wire [63:0] vector_table_base,
  output wire [63:0] local_table_base,
  output wire [63:0] task_table_base,
  // Mode attributes
  output wire        mode_64,
  output wire        mode_compat,
  output wire        mode_legacy,
  output wire        real_v86_ok,
  output wire        hw_task_switch_ok,
  output wire        seg_base_ignore,
  output wire        seg_limit_ignore,
  output wire [4:0]  vec_entry_bytes,
  output wire [3:0]  push_bytes,
  output wire        stack_ptr_push_always,
  output wire        stack_seg_keep,
  output wire        call_gate16_illegal,
  output wire [4:0]  call_gate32_bytes,
  output wire [3:0]  pseudo_desc_bytes,
  output wire [4:0]  sys_entry_bytes,
  output wire [2:0]  paging_levels
);

  // Physical address mask for the table base
  localparam [63:0] TB_MASK = (PA_WIDTH >= 64) ? `SCRA_MASK_ALL :
                              ((64'h0000000000000001 << PA_WIDTH) - 64'h0000000000000001);

  wire [63:0] mode_ctl_val;
  wire [63:0] extra_ctl_val;
  wire [63:0] prio_val;
  wire [63:0] dt_val [0:3];

  wire        pae_on;
  reg  [63:0] wdata_eff;
  reg         idx_mode_ctl;
  reg         idx_fault;
  reg         idx_table;
  reg         idx_extra;
  reg         idx_prio;
  reg         idx_ok;
  reg         upper_bad;
  reg         pae_bad;
  reg         gp_hit;
  reg         wr_ok;
  reg  [63:0] rd_sel;

  wire        wr_mode_ctl;
  wire        wr_fault;
  wire        wr_table;
  wire        wr_extra;
  wire        wr_prio;
  wire [63:0] fault_wdata;
  wire [63:0] dt_base_eff;
  wire [3:0]  dt_we;

  assign pae_on = extra_ctl_val[PAE_BIT];

  scra_mode u_mode (
    .long_active           (long_active),
    .code_long             (code_long),
    .pae_on                (pae_on),
    .gate32                (gate32),
    .mode_64               (mode_64),
    .mode_compat           (mode_compat),
    .mode_legacy           (mode_legacy),
    .real_v86_ok           (real_v86_ok),
    .hw_task_switch_ok     (hw_task_switch_ok),
    .seg_base_ignore       (seg_base_ignore),
    .seg_limit_ignore      (seg_limit_ignore),
    .vec_entry_bytes       (vec_entry_bytes),
    .push_bytes            (push_bytes),
    .stack_ptr_push_always (stack_ptr_push_always),
    .stack_seg_keep        (stack_seg_keep),
    .call_gate16_illegal   (call_gate16_illegal),
    .call_gate32_bytes     (call_gate32_bytes),
    .pseudo_desc_bytes     (pseudo_desc_bytes),
    .sys_entry_bytes       (sys_entry_bytes),
    .paging_levels         (paging_levels)
  );

  // Index decode; the extension prefix opens index 8 only in 64-bit mode
  always @* begin
    idx_mode_ctl = 1'b0;
    idx_fault    = 1'b0;
    idx_table    = 1'b0;
    idx_extra    = 1'b0;
    idx_prio     = 1'b0;
    case (req_index)
      `SCRA_IDX_MODE_CTL: begin
        idx_mode_ctl = 1'b1;
      end
      `SCRA_IDX_FAULT_ADDR: begin
        idx_fault = 1'b1;
      end
      `SCRA_IDX_TABLE_BASE: begin
        idx_table = 1'b1;
      end
      `SCRA_IDX_EXTRA_CTL: begin
        idx_extra = 1'b1;
      end
      `SCRA_IDX_PRIO_THRESH: begin
        idx_prio = mode_64 & req_rex;
      end
      default: begin
        idx_mode_ctl = 1'b0;
      end
    endcase
    idx_ok = idx_mode_ctl | idx_fault | idx_table | idx_extra | idx_prio;
  end

  // Width handling; operand size is ignored in every mode
  always @* begin
    if (mode_64) begin
      wdata_eff = req_wdata;
    end else begin
      wdata_eff = {{`SCRA_HALF_W{1'b0}}, req_wdata[31:0]};
    end
  end

  // Fault checks on writes
  always @* begin
    upper_bad = mode_64 & (idx_mode_ctl | idx_extra) & (|req_wdata[63:32]);
    pae_bad   = long_active & idx_extra & ~wdata_eff[PAE_BIT];
    gp_hit    = req_write & (upper_bad | pae_bad);
    wr_ok     = req_valid & req_write & idx_ok & ~gp_hit;
  end

  assign wr_mode_ctl = wr_ok & idx_mode_ctl;
  assign wr_fault    = (wr_ok & idx_fault) | pf_valid;
  assign wr_table    = wr_ok & idx_table;
  assign wr_extra    = wr_ok & idx_extra;
  assign wr_prio     = wr_ok & idx_prio;

  // A page fault in the same cycle as a move wins: it is the newer event
  assign fault_wdata = pf_valid ? pf_addr : wdata_eff;

  scra_reg #(
    .RST_VAL (`SCRA_RST_MODE_CTL),
    .WR_MASK (`SCRA_MASK_ALL)
  ) u_mode_ctl (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .wr_en   (wr_mode_ctl),
    .wr_data (wdata_eff),
    .value   (mode_ctl_val)
  );

  scra_reg #(
    .RST_VAL (`SCRA_RST_ZERO),
    .WR_MASK (`SCRA_MASK_ALL)
  ) u_fault (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .wr_en   (wr_fault),
    .wr_data (fault_wdata),
    .value   (fault_address_reg)
  );

  scra_reg #(
    .RST_VAL (`SCRA_RST_ZERO),
    .WR_MASK (TB_MASK)
  ) u_table (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .wr_en   (wr_table),
    .wr_data (wdata_eff),
    .value   (table_base_reg)
  );

  scra_reg #(
    .RST_VAL (`SCRA_RST_ZERO),
    .WR_MASK (`SCRA_MASK_ALL)
  ) u_extra (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .wr_en   (wr_extra),
    .wr_data (wdata_eff),
    .value   (extra_ctl_val)
  );

  scra_reg #(
    .RST_VAL (`SCRA_RST_ZERO),
    .WR_MASK (`SCRA_MASK_PRIO)
  ) u_prio (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .wr_en   (wr_prio),
    .wr_data (wdata_eff),
    .value   (prio_val)
  );

  // Upper flag bits are dropped without any fault
  scra_reg #(
    .RST_VAL (`SCRA_RST_FLAGS),
    .WR_MASK (`SCRA_MASK_LOW32)
  ) u_flags (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .wr_en   (flags_wr),
    .wr_data (flags_wdata),
    .value   (flags_status_control_reg)
  );

  // Full width regardless of mode
  scra_reg #(
    .RST_VAL (`SCRA_RST_ZERO),
    .WR_MASK (`SCRA_MASK_ALL)
  ) u_extended_feature_enable_reg (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .wr_en   (extended_feature_enable_reg_wr),
    .wr_data (extended_feature_enable_reg_wdata),
    .value   (extended_feature_enable_reg)
  );

  // Outside 64-bit mode a pseudo-descriptor carries only a 32-bit base
  assign dt_base_eff = mode_64 ? dt_load_base :
                       {{`SCRA_HALF_W{1'b0}}, dt_load_base[31:0]};

  assign dt_we = {3'h0, dt_load_valid} << dt_load_sel;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_dt
      scra_reg #(
        .RST_VAL (`SCRA_RST_ZERO),
        .WR_MASK (`SCRA_MASK_ALL)
      ) u_dt (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .wr_en   (dt_we[g]),
        .wr_data (dt_base_eff),
        .value   (dt_val[g])
      );
    end
  endgenerate

  assign global_table_base = dt_val[`SCRA_DT_GLOBAL];
  assign vector_table_base = dt_val[`SCRA_DT_VECTOR];
  assign local_table_base  = dt_val[`SCRA_DT_LOCAL];
  assign task_table_base   = dt_val[`SCRA_DT_TASK];

  assign mode_feature_control_reg = mode_ctl_val;
  assign extra_mode_control_reg   = extra_ctl_val;
  assign priority_threshold_reg   = prio_val[3:0];

  // Read mux; narrow modes see only the low half
  always @* begin
    rd_sel = `SCRA_RST_ZERO;
    if (idx_mode_ctl) begin
      rd_sel = mode_ctl_val;
    end else if (idx_fault) begin
      rd_sel = fault_address_reg;
    end else if (idx_table) begin
      rd_sel = table_base_reg;
    end else if (idx_extra) begin
      rd_sel = extra_ctl_val;
    end else if (idx_prio) begin
      rd_sel = prio_val;
    end
    if (!mode_64) begin
      rd_sel = {{`SCRA_HALF_W{1'b0}}, rd_sel[31:0]};
    end
  end

  // Answer one cycle after the request
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid    <= 1'b0;
      rsp_rdata    <= `SCRA_RST_ZERO;
      rsp_gp_fault <= 1'b0;
      rsp_err_code <= `SCRA_GP_ERR_CODE;
      rsp_ud_fault <= 1'b0;
    end else begin
      rsp_valid    <= req_valid;
      rsp_gp_fault <= req_valid & idx_ok & gp_hit;
      rsp_err_code <= `SCRA_GP_ERR_CODE;
      rsp_ud_fault <= req_valid & ~idx_ok;
      if (req_valid & ~req_write & idx_ok) begin
        rsp_rdata <= rd_sel;
      end else if (req_valid) begin
        rsp_rdata <= `SCRA_RST_ZERO;
      end
    end
  end

endmodule // scra_top

/* File: verif/scra_checker.sv */
`include "scra_defs.vh"

module scra_checker #(
  parameter PA_WIDTH = 40
) (
  // Clock and reset
  input logic        mclk,
  input logic        rst_n,
  // Mode inputs
  input logic        long_active,
  input logic        code_long,
  // Move request and answer
  input logic        req_valid,
  input logic        req_write,
  input logic [3:0]  req_index,
  input logic        req_rex,
  input logic [63:0] req_wdata,
  input logic        rsp_gp_fault,
  input logic [15:0] rsp_err_code,
  input logic        rsp_ud_fault,
  input logic [63:0] rsp_rdata,
  // Side loads
  input logic        extended_feature_enable_reg_wr,
  input logic [63:0] extended_feature_enable_reg_wdata,
  input logic        pf_valid,
  input logic [63:0] pf_addr,
  // Register contents
  input logic [63:0] mode_feature_control_reg,
  input logic [63:0] fault_address_reg,
  input logic [63:0] table_base_reg,
  input logic [63:0] extra_mode_control_reg,
  input logic [3:0]  priority_threshold_reg,
  input logic [63:0] flags_status_control_reg,
  input logic [63:0] extended_feature_enable_reg,
  // Mode attributes
  input logic        mode_64,
  input logic        mode_compat,
  input logic        real_v86_ok,
  input logic        hw_task_switch_ok,
  input logic        seg_base_ignore,
  input logic        seg_limit_ignore,
  input logic [4:0]  vec_entry_bytes,
  input logic [3:0]  push_bytes,
  input logic [2:0]  paging_levels
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Page fault wins over a same-cycle move, so moves to index 2 exclude it
  wire mv_wr2 = req_valid && req_write && req_index == 4'h2 && !pf_valid;
  wire rsv_idx = req_index == 4'h1 || (req_index >= 4'h5 && req_index <= 4'h7) || req_index >= 4'h9;

  a_wide_write: assert property (mv_wr2 && mode_64 |=> fault_address_reg == $past(req_wdata))
    else $error("wide move write lost bits");
  a_narrow_write: assert property (mv_wr2 && !mode_64 |=> fault_address_reg == {32'h0, $past(req_wdata[31:0])})
    else $error("narrow move write upper half not zero");
  a_narrow_read: assert property (req_valid && !req_write && !mode_64 |=> rsp_rdata[63:32] == 32'h0)
    else $error("narrow move read upper half not zero");
  a_upper_fault: assert property (mode_64 && req_valid && req_write
    && (req_index == 4'h0 || req_index == 4'h4) && req_wdata[63:32] != 32'h0
    |=> rsp_gp_fault && rsp_err_code == 16'h0 && $stable(mode_feature_control_reg)
    && $stable(extra_mode_control_reg))
    else $error("reserved upper control bits not refused");
  a_table_width: assert property ((table_base_reg >> PA_WIDTH) == 64'h0)
    else $error("table base holds unimplemented bits");
  a_flags_upper: assert property (flags_status_control_reg[63:32] == 32'h0)
    else $error("flags upper half not zero");
  a_feature_full: assert property (extended_feature_enable_reg_wr |=> extended_feature_enable_reg == $past(extended_feature_enable_reg_wdata))
    else $error("feature enable load not full width");
  a_reserved_idx: assert property (req_valid && rsv_idx |=> rsp_ud_fault && !rsp_gp_fault)
    else $error("reserved index not refused");
  a_prio_gated: assert property (req_valid && req_index == 4'h8 && !(mode_64 && req_rex)
    |=> rsp_ud_fault && $stable(priority_threshold_reg))
    else $error("priority threshold reached without prefix");
  a_pf_load: assert property (pf_valid |=> fault_address_reg == $past(pf_addr))
    else $error("page fault address not loaded");
  a_long_struct: assert property (long_active |-> !real_v86_ok
    && !hw_task_switch_ok && vec_entry_bytes == `SCRA_VEC_ENTRY_LONG && push_bytes == `SCRA_PUSH_LONG
    && paging_levels == `SCRA_PAGING_LONG)
    else $error("long mode structure attributes wrong");
  a_seg_ignore: assert property (seg_base_ignore == (long_active && code_long)
    && seg_limit_ignore == (long_active && code_long))
    else $error("segment ignore does not follow mode");
endmodule // scra_checker

bind scra_top scra_checker #(.PA_WIDTH(PA_WIDTH)) u_chk (.*);

/* File: verif/scra_exec_model.sv */
module scra_exec_model (
  // Clock
  input  logic        mclk,
  // Move request
  output logic        req_valid,
  output logic        req_write,
  output logic [3:0]  req_index,
  output logic        req_rex,
  output logic        req_opsize,
  output logic [63:0] req_wdata,
  // Move answer
  input  logic        rsp_valid,
  input  logic [63:0] rsp_rdata,
  input  logic        rsp_gp_fault,
  input  logic [15:0] rsp_err_code,
  input  logic        rsp_ud_fault
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    req_valid = 1'h0;
    req_write = 1'h0;
    req_index = 4'h0;
    req_rex = 1'h0;
    req_opsize = 1'h0;
    req_wdata = 64'h0;
  end
  // Data is whatever the caller asks; zero upper bits, implemented table bits and the
  // extension bit are kept unless a scenario breaks them on purpose
  task automatic move(input logic w, input logic [3:0] i, input logic x, input logic o, input logic [63:0] d,
                      output logic v, output logic [63:0] rd, output logic gp, output logic [15:0] ec,
                      output logic ud);
    @(negedge mclk);
    req_valid = 1'h1;
    req_write = w;
    req_index = i;
    req_rex = x;
    req_opsize = o;
    req_wdata = d;
    @(negedge mclk);
    v = rsp_valid;
    rd = rsp_rdata;
    gp = rsp_gp_fault;
    ec = rsp_err_code;
    ud = rsp_ud_fault;
    req_valid = 1'h0;
    // Idle bus must not keep showing the last value
    req_wdata = ~d;
  endtask
endmodule // scra_exec_model

/* File: verif/system_control_reg_access_bench.sv */
`include "scra_defs.vh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fail_count++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end

module system_control_reg_access_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PA_W = 40;
  localparam logic [63:0] PA_MASK = {64{1'h1}} >> (64 - PA_W);
  localparam logic [63:0] DT_B = 64'hFEDC000000000000;
  // Flags: long_active, code_long, write, prefix, expect fault, expect reserved
  typedef struct packed {
    logic [5:0]  f;
    logic [3:0]  idx;
    logic [63:0] wd, rd;
  } scra_row_t;
  logic        mclk = 1'h0, rst_n = 1'h0, long_active = 1'h1, code_long = 1'h1, gate32 = 1'h1;
  logic        flags_wr = 1'h0, extended_feature_enable_reg_wr = 1'h0, pf_valid = 1'h0, dt_load_valid = 1'h0;
  logic [1:0]  dt_load_sel = 2'h0;
  logic [63:0] flags_wdata = 64'h0, extended_feature_enable_reg_wdata = 64'h0, pf_addr = 64'h0, dt_load_base = 64'h0;
  wire         req_valid, req_write, req_rex, req_opsize, rsp_valid, rsp_gp_fault, rsp_ud_fault;
  wire  [3:0]  req_index, priority_threshold_reg, push_bytes, pseudo_desc_bytes;
  wire  [63:0] req_wdata, rsp_rdata, mode_feature_control_reg, fault_address_reg, table_base_reg;
  wire  [63:0] extra_mode_control_reg, flags_status_control_reg, extended_feature_enable_reg;
  wire  [63:0] global_table_base, vector_table_base, local_table_base, task_table_base;
  wire  [15:0] rsp_err_code;
  wire  [4:0]  vec_entry_bytes, call_gate32_bytes, sys_entry_bytes;
  wire  [2:0]  paging_levels;
  wire         mode_64, mode_compat, mode_legacy, real_v86_ok, hw_task_switch_ok, seg_base_ignore;
  wire         seg_limit_ignore, stack_ptr_push_always, stack_seg_keep, call_gate16_illegal;
  wire [255:0] dt_all = {task_table_base, local_table_base, vector_table_base, global_table_base};
  int          fail_count = 0, comparisons = 0;
  logic        v, gp, ud;
  logic [15:0] ec;
  logic [63:0] rd;
  scra_row_t   rows [20];

  scra_top #(.PA_WIDTH(PA_W)) uut (.*);
  scra_exec_model u_core (.*);

  always #50 mclk = ~mclk;

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check_mode(input logic la, input logic cl, input logic [35:0] ex);
    @(negedge mclk);
    long_active = la;
    code_long = cl;
    #1;
    `CHK("mode", ex, {mode_64, mode_compat, mode_legacy, real_v86_ok, hw_task_switch_ok, seg_base_ignore,
      seg_limit_ignore, vec_entry_bytes, push_bytes, stack_ptr_push_always, stack_seg_keep, call_gate16_illegal,
      call_gate32_bytes, pseudo_desc_bytes, sys_entry_bytes, paging_levels})
  endtask

  initial begin
    #200000;
    fail_count++;
    finish_test;
  end

  initial begin
    rows = '{'{6'h38, 4'h2, 64'hFEDCBA9876543210, 64'h0},
             '{6'h30, 4'h2, 64'h0, 64'hFEDCBA9876543210},
             '{6'h28, 4'h3, 64'hFFFFFFFF12345000, 64'h0},
             '{6'h30, 4'h3, 64'h0, 64'h0000000012345000},
             '{6'h20, 4'h2, 64'h0, 64'h0000000076543210},
             '{6'h00, 4'h2, 64'h0, 64'h0000000076543210},
             '{6'h3A, 4'h0, 64'h0000000100000000, 64'h0},
             '{6'h30, 4'h0, 64'h0, `SCRA_RST_MODE_CTL},
             '{6'h3A, 4'h4, 64'h8000000000000020, 64'h0},
             '{6'h38, 4'h4, 64'h0000000000000020, 64'h0},
             '{6'h30, 4'h4, 64'h0, 64'h0000000000000020},
             '{6'h3A, 4'h4, 64'h0, 64'h0},
             '{6'h31, 4'h8, 64'h0, 64'h0},
             '{6'h25, 4'h8, 64'h0, 64'h0},
             '{6'h3C, 4'h8, 64'h000000000000000F, 64'h0},
             '{6'h34, 4'h8, 64'h0, 64'h000000000000000F},
             '{6'h38, 4'h3, 64'hFFFFFFFFFFFFFFFF, 64'h0},
             '{6'h30, 4'h3, 64'h0, PA_MASK},
             '{6'h08, 4'h2, 64'hAAAAAAAA55555555, 64'h0},
             '{6'h30, 4'h2, 64'h0, 64'h0000000055555555}};
    repeat (6) @(posedge mclk);
    `CHK("reset", {`SCRA_RST_MODE_CTL, `SCRA_RST_ZERO, `SCRA_RST_FLAGS, `SCRA_RST_ZERO},
      {mode_feature_control_reg, extra_mode_control_reg, flags_status_control_reg, fault_address_reg})
    @(negedge mclk);
    rst_n = 1'h1;
    foreach (rows[i]) begin
      long_active = rows[i].f[5];
      code_long = rows[i].f[4];
      // Operand-size prefix follows index bit 0; it must make no difference
      u_core.move(rows[i].f[3], rows[i].idx, rows[i].f[2], rows[i].idx[0], rows[i].wd, v, rd, gp, ec, ud);
      `CHK("move", {1'h1, rows[i].rd, rows[i].f[1], 16'h0, rows[i].f[0]}, {v, rd, gp, ec, ud})
    end
    for (int i = 0; i < 16; i++) begin
      if (!(i inside {0, 2, 3, 4, 8})) begin
        u_core.move(1'h1, 4'(i), 1'h1, 1'h0, 64'hFFFFFFFFFFFFFFFF, v, rd, gp, ec, ud);
        `CHK("reserved", 3'h5, {v, gp, ud})
      end
    end
    `CHK("state kept", {64'h0000000055555555, PA_MASK, 4'hF},
      {fault_address_reg, table_base_reg, priority_threshold_reg})
    fork
      begin
        @(negedge mclk);
        pf_valid = 1'h1;
        pf_addr = 64'h0123456789ABCDEF;
        @(negedge mclk);
        pf_valid = 1'h0;
        pf_addr = 64'hFEDCBA9876543210;
      end
      u_core.move(1'h1, 4'h2, 1'h0, 1'h0, 64'h1111111111111111, v, rd, gp, ec, ud);
    join
    `CHK("page fault", 64'h0123456789ABCDEF, fault_address_reg)
    for (int i = 0; i < 4; i++) begin
      @(negedge mclk);
      dt_load_valid = 1'h1;
      dt_load_sel = 2'(i);
      dt_load_base = DT_B + 64'(i);
    end
    @(negedge mclk);
    dt_load_valid = 1'h0;
    for (int i = 0; i < 4; i++) `CHK("table base", DT_B + 64'(i), dt_all[i*64 +: 64])
    flags_wr = 1'h1;
    flags_wdata = 64'hFFFFFFFF00000ACE;
    extended_feature_enable_reg_wr = 1'h1;
    extended_feature_enable_reg_wdata = 64'hFFFFFFFFFFFFFFFF;
    long_active = 1'h0;
    code_long = 1'h0;
    @(negedge mclk);
    flags_wr = 1'h0;
    extended_feature_enable_reg_wr = 1'h0;
    `CHK("flags", 64'h0000000000000ACE, flags_status_control_reg)
    `CHK("feature enable", 64'hFFFFFFFFFFFFFFFF, extended_feature_enable_reg)
    dt_load_valid = 1'h1;
    dt_load_sel = 2'h3;
    @(negedge mclk);
    dt_load_valid = 1'h0;
    `CHK("narrow table base", 64'h0000000000000003, task_table_base)
    check_mode(1'h1, 1'h1, {7'h43, `SCRA_VEC_ENTRY_LONG, `SCRA_PUSH_LONG, 3'h7, `SCRA_GATE_LONG,
      `SCRA_PSEUDO_LONG, `SCRA_SYS_ENTRY_LONG, `SCRA_PAGING_LONG});
    check_mode(1'h1, 1'h0, {7'h20, `SCRA_VEC_ENTRY_LONG, `SCRA_PUSH_LONG, 3'h6, `SCRA_GATE_LEG,
      `SCRA_PSEUDO_LEG, `SCRA_SYS_ENTRY_LEG, `SCRA_PAGING_LONG});
    check_mode(1'h0, 1'h0, {7'h1C, `SCRA_VEC_ENTRY_LEG, `SCRA_PUSH_LEG32, 3'h0, `SCRA_GATE_LEG,
      `SCRA_PSEUDO_LEG, `SCRA_SYS_ENTRY_LEG, `SCRA_PAGING_PAE});
    @(negedge mclk);
    rst_n = 1'h0;
    @(negedge mclk);
    `CHK("mid reset", {`SCRA_RST_MODE_CTL, `SCRA_RST_FLAGS, `SCRA_RST_ZERO},
      {mode_feature_control_reg, flags_status_control_reg, extended_feature_enable_reg})
    rst_n = 1'h1;
    gate32 = 1'h0;
    u_core.move(1'h0, 4'h0, 1'h0, 1'h0, 64'h0, v, rd, gp, ec, ud);
    `CHK("read after reset", {1'h1, `SCRA_RST_MODE_CTL}, {v, rd})
    // Reset cleared the extension bit, so legacy paging falls back to two levels
    check_mode(1'h0, 1'h0, {7'h1C, `SCRA_VEC_ENTRY_LEG, `SCRA_PUSH_LEG16, 3'h0, `SCRA_GATE_LEG,
      `SCRA_PSEUDO_LEG, `SCRA_SYS_ENTRY_LEG, `SCRA_PAGING_PLAIN});
    finish_test;
  end
endmodule // system_control_reg_access_bench
